// ==== hw/cts_policy_top.sv ====
/*
  Chassis manager startup ordering, insertion handling and thermal policy.
  Assumes presence, handshake and thermal inputs are synchronous to clk.
*/
// Functional notes
// - I/O modules and primary switch come up before blade management starts.
// - Blade management networking starts after switch init; then blade power-on.
// - Fan speed lowered only once thermal knowledge is complete.
// - Each removable module has exactly one presence line for inventory.
// - Insertion handler communicates with the module first, then initialises it.
// - Two selectable policies: cooling-optimised and acoustics-optimised.
// - Cooling policy holds blade thermal state at level 2.
// - Acoustic policy holds blade thermal state at level 3.
// - State 4 raises zone fan speed until back at 2 or 3.
// - State 5 raises cooling more than state 4.
// - State 6 commands full cooling for the zone.
// - State 7 commands full cooling and shuts the blade down.
// - Acoustic mode slows fans at state 2, speeds them at 4 or 5.
`timescale 1ns/1ps
`default_nettype none
module cts_policy_top import cts_pkg::*; #(
  parameter logic [CNT_W-1:0] ADJ_CYCLES  = ADJ_CYC[CNT_W-1:0],
  parameter logic [CNT_W-1:0] COMM_CYCLES = COMM_TO_CYC[CNT_W-1:0]
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   acoustic_mode,
  input  wire logic                   thermal_known,
  input  wire logic                   psu_mgmt_up,
  input  wire logic [NUM_MOD-1:0]     present,
  input  wire logic [NUM_MOD-1:0]     comm_ack,
  input  wire logic [NUM_MOD-1:0]     init_done,
  input  wire logic [NUM_BLADE*3-1:0] blade_therm,
  output var  logic [NUM_MOD-1:0]     comm_req,
  output var  logic [NUM_MOD-1:0]     init_req,
  output var  logic [NUM_MOD-1:0]     mod_ready,
  output var  logic                   blade_mgmt_en,
  output var  logic                   blade_pwr_permit,
  output var  logic                   regulating,
  output var  logic [NUM_BLADE-1:0]   blade_shutdown,
  output var  logic [NUM_ZONE*8-1:0]  fan_cmd
);
  // ************************************************************
  // Startup sequencer state
  // ************************************************************
  cts_su_type             su_r, su_nxt;
  logic                   bmi_r, bmi_nxt;
  logic                   permit_r, permit_nxt;
  logic                   reg_r, reg_nxt;
  logic [NUM_BLADE-1:0]   shut_r, shut_nxt;
  logic [CNT_W-1:0]       adj_r, adj_nxt;
  logic                   tick_r, tick_nxt;
  cts_hs_type             hs [NUM_MOD];
  logic                   iom_ok, blade_ok;
  logic [NUM_BLADE*3-1:0] masked;
  logic [2:0]             zmax [NUM_ZONE];

  // ************************************************************
  // Per-module insertion handlers
  // ************************************************************
  for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
    cts_insert_fsm #(
      .TO_CYC (COMM_CYCLES)
    ) u_ih (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .present   (present[m]),
      .go        ((m >= BLADE_BASE) ? bmi_r : 1'b1),
      .comm_ack  (comm_ack[m]),
      .init_done (init_done[m]),
      .hs        (hs[m])
    );
    assign comm_req[m]  = hs[m].comm_req;
    assign init_req[m]  = hs[m].init_req;
    assign mod_ready[m] = hs[m].ready;
  end

  // ************************************************************
  // Readiness summaries and zone maxima
  // ************************************************************
  always_comb begin
    iom_ok = hs[PRI_SW].ready;
    for (int i = IOM_BASE; i < IOM_BASE + NUM_IOM; i++) begin
      if (present[i] && !hs[i].ready) iom_ok = 1'b0;
    end
    blade_ok = 1'b1;
    for (int b = 0; b < NUM_BLADE; b++) begin
      if (present[BLADE_BASE + b] && !hs[BLADE_BASE + b].ready) blade_ok = 1'b0;
      masked[b*3 +: 3] = present[BLADE_BASE + b] ? blade_therm[b*3 +: 3] : TS_OFF;
    end
    for (int z = 0; z < NUM_ZONE; z++) begin
      zmax[z] = 3'h0;
      for (int k = 0; k < BPZ; k++) begin
        zmax[z] = cts_max3(zmax[z], masked[(z*BPZ + k)*3 +: 3]);
      end
    end
  end

  // ************************************************************
  // Startup ordering: supplies, I/O modules, blade management, power
  // ************************************************************
  always_comb begin
    su_nxt = su_r;
    case (su_r)
      SU_PWR: if (psu_mgmt_up) su_nxt = SU_IOM;
      SU_IOM: if (iom_ok) su_nxt = SU_BMI;
      SU_BMI: begin
        if (!hs[PRI_SW].ready) su_nxt = SU_IOM;
        else if (blade_ok) su_nxt = SU_RUN;
      end
      SU_RUN: if (!hs[PRI_SW].ready) su_nxt = SU_IOM;
      default: su_nxt = SU_PWR;
    endcase
    bmi_nxt    = (su_nxt == SU_BMI) || (su_nxt == SU_RUN);
    permit_nxt = (su_nxt == SU_RUN);
    reg_nxt    = (su_nxt == SU_RUN) && thermal_known;
    for (int b = 0; b < NUM_BLADE; b++) begin
      shut_nxt[b] = (masked[b*3 +: 3] == TS_CRITICAL);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      su_r     <= SU_PWR;
      bmi_r    <= 1'b0;
      permit_r <= 1'b0;
      reg_r    <= 1'b0;
      shut_r   <= '0;
    end else begin
      su_r     <= su_nxt;
      bmi_r    <= bmi_nxt;
      permit_r <= permit_nxt;
      reg_r    <= reg_nxt;
      shut_r   <= shut_nxt;
    end
  end

  // ************************************************************
  // Regulation step timer
  // ************************************************************
  always_comb begin
    adj_nxt  = adj_r + 1'b1;
    tick_nxt = 1'b0;
    if (adj_r == ADJ_CYCLES - 1'b1) begin
      adj_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adj_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      adj_r  <= adj_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ************************************************************
  // Zone fan controllers
  // ************************************************************
  for (genvar z = 0; z < NUM_ZONE; z++) begin : g_zone
    cts_zone_fan u_zf (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick     (tick_r),
      .regulate (reg_r),
      .acoustic (acoustic_mode),
      .states   (masked[z*BPZ*3 +: BPZ*3]),
      .fan_cmd  (fan_cmd[z*8 +: 8])
    );
  end

  assign blade_mgmt_en    = bmi_r;
  assign blade_pwr_permit = permit_r;
  assign regulating       = reg_r;
  assign blade_shutdown   = shut_r;

  // ************************************************************
  // Checks on zone 0 and the sequencer
  // ************************************************************
  logic [7:0] fan0;
  assign fan0 = fan_cmd[7:0];

  mgmt_after_switch_a: assert property (@(posedge clk) disable iff (sys_rst)
    blade_mgmt_en |-> $past(hs[PRI_SW].ready))
    else $error("blade management enabled before primary switch ready");

  permit_after_mgmt_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(blade_pwr_permit) |-> $past(blade_mgmt_en))
    else $error("blade power permitted before management networking");

  psu_before_io_a: assert property (@(posedge clk) disable iff (sys_rst)
    (su_r == SU_PWR && !psu_mgmt_up) |=> (su_r == SU_PWR))
    else $error("startup left supply stage without supply management");

  full_until_known_a: assert property (@(posedge clk) disable iff (sys_rst)
    !regulating |=> (fan0 == FAN_FULL))
    else $error("fan lowered before thermal knowledge complete");

  blade_go_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(comm_req[BLADE_BASE]) |-> $past(blade_mgmt_en) && $past(present[BLADE_BASE]))
    else $error("blade contacted before management enabled");

  ready_needs_present_a: assert property (@(posedge clk) disable iff (sys_rst)
    mod_ready[0] |-> $past(present[0]))
    else $error("module ready without presence");

  warn_full_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regulating && zmax[0] == TS_WARNING) |=> (fan0 == FAN_FULL))
    else $error("state 6 did not force full cooling");

  crit_shutdown_a: assert property (@(posedge clk) disable iff (sys_rst)
    (masked[2:0] == TS_CRITICAL) |=> blade_shutdown[0] ##0 (!regulating || fan0 == FAN_FULL))
    else $error("state 7 did not shut down blade with full cooling");

  hot_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regulating && tick_r && zmax[0] == TS_HOT && reg_nxt && fan0 <= FAN_FULL - STEP_HOT)
    |=> (fan0 == $past(fan0) + STEP_HOT))
    else $error("state 4 did not raise fan by one step");

  hotter_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regulating && tick_r && zmax[0] == TS_HOTTER && reg_nxt
     && fan0 <= FAN_FULL - STEP_HOTTER)
    |=> (fan0 == $past(fan0) + STEP_HOTTER))
    else $error("state 5 did not raise fan by the larger step");

  cool_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regulating && reg_nxt && !acoustic_mode && zmax[0] == TS_COOL) |=> $stable(fan0))
    else $error("cooling policy moved fan at target state");

  acoustic_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regulating && reg_nxt && acoustic_mode && zmax[0] == TS_WARM) |=> $stable(fan0))
    else $error("acoustic policy moved fan at target state");

  acoustic_slow_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regulating && reg_nxt && tick_r && acoustic_mode && zmax[0] == TS_COOL
     && fan0 >= FAN_MIN + STEP_DOWN)
    |=> (fan0 == $past(fan0) - STEP_DOWN))
    else $error("acoustic policy did not slow fans at state 2");

  tick_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick_r |=> !tick_r)
    else $error("regulation tick longer than one cycle");

  startup_run_c: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(blade_pwr_permit));
  insert_ready_c: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(mod_ready[BLADE_BASE]));
  crit_event_c: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(blade_shutdown[0]));
  fan_slowed_c: cover property (@(posedge clk) disable iff (sys_rst)
    regulating && fan0 < FAN_FULL);

  // ************************************************************
  // Checks on zone 1, removal, switch loss and the step timer
  // ************************************************************
  logic [7:0] fan1;
  assign fan1 = fan_cmd[15:8];

  warn_full_z1_a: assert property (@(posedge clk) disable iff (sys_rst)
    (zmax[1] >= TS_WARNING) |=> (fan1 == FAN_FULL))
    else $error("hot zone 1 blade did not force full cooling");

  permit_needs_mgmt_a: assert property (@(posedge clk) disable iff (sys_rst)
    blade_pwr_permit |-> blade_mgmt_en)
    else $error("blade power permitted without management networking");

  pwr_stage_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    (su_r == SU_PWR) |-> !blade_mgmt_en)
    else $error("blade management enabled in supply stage");

  switch_loss_a: assert property (@(posedge clk) disable iff (sys_rst)
    (blade_mgmt_en && !mod_ready[PRI_SW]) |=> !blade_mgmt_en)
    else $error("blade management kept after primary switch loss");

  removal_drop_a: assert property (@(posedge clk) disable iff (sys_rst)
    !present[BLADE_BASE] |=> !comm_req[BLADE_BASE] && !init_req[BLADE_BASE]
    && !mod_ready[BLADE_BASE])
    else $error("removed blade still in handshake");

  shutdown_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (masked[2:0] != TS_CRITICAL) |=> !blade_shutdown[0])
    else $error("blade shutdown without critical state");

  warm_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    (regulating && tick_r && !acoustic_mode && zmax[0] == TS_WARM
     && fan0 <= FAN_FULL - STEP_HOT)
    |=> (fan0 == $past(fan0) + STEP_HOT))
    else $error("cooling policy did not raise fan at state 3");

  tick_spacing_a: assert property (@(posedge clk) disable iff (sys_rst)
    (adj_r == ADJ_CYCLES - 1'b1) |=> tick_r)
    else $error("regulation tick missing at end of period");

  acoustic_hold_c: cover property (@(posedge clk) disable iff (sys_rst)
    regulating && acoustic_mode && zmax[0] == TS_WARM && tick_r);
endmodule
`default_nettype wire

// ==== include/cts_pkg.sv ====
/*
  Shared constants, types and helpers for the chassis thermal and startup
  policy block. Assumes a single 250 MHz clock.
*/
`default_nettype none
package cts_pkg;
  // Module population and slot layout; slot 0 is the primary switch.
  localparam int NUM_IOM    = 2;
  localparam int NUM_PSU    = 2;
  localparam int NUM_FAN    = 2;
  localparam int NUM_BLADE  = 4;
  localparam int NUM_ZONE   = 2;
  localparam int BPZ        = 2;
  localparam int IOM_BASE   = 0;
  localparam int PSU_BASE   = 2;
  localparam int FAN_BASE   = 4;
  localparam int BLADE_BASE = 6;
  localparam int NUM_MOD    = 10;
  localparam int PRI_SW     = 0;
  // Timing: regulation step period and module answer timeout.
  localparam int CLK_NS        = 4;
  localparam int ADJ_PERIOD_NS = 100000;
  localparam int ADJ_CYC       = ADJ_PERIOD_NS / CLK_NS;
  localparam int COMM_TO_NS    = 1000000;
  localparam int COMM_TO_CYC   = COMM_TO_NS / CLK_NS;
  localparam int CNT_W         = 20;
  // Fan command scale and regulation steps.
  localparam logic [7:0] FAN_FULL    = 8'hFF;
  localparam logic [7:0] FAN_MIN     = 8'h20;
  localparam logic [7:0] STEP_HOT    = 8'h08;
  localparam logic [7:0] STEP_HOTTER = 8'h20;
  localparam logic [7:0] STEP_DOWN   = 8'h04;
  typedef enum logic [2:0] {
    TS_OFF = 3'h0, TS_COLD = 3'h1, TS_COOL = 3'h2, TS_WARM = 3'h3,
    TS_HOT = 3'h4, TS_HOTTER = 3'h5, TS_WARNING = 3'h6, TS_CRITICAL = 3'h7
  } cts_therm_type;
  typedef enum logic [1:0] {
    SU_PWR = 2'h0, SU_IOM = 2'h1, SU_BMI = 2'h3, SU_RUN = 2'h2
  } cts_su_type;
  typedef enum logic [1:0] {
    IH_IDLE = 2'h0, IH_COMM = 2'h1, IH_INIT = 2'h3, IH_READY = 2'h2
  } cts_ih_type;
  typedef struct packed {
    logic comm_req;
    logic init_req;
    logic ready;
  } cts_hs_type;
  // Larger of two thermal state codes.
  function automatic logic [2:0] cts_max3(input logic [2:0] a, input logic [2:0] b);
    return (a > b) ? a : b;
  endfunction
endpackage
`default_nettype wire

// ==== hw/cts_insert_fsm.sv ====
/*
  Insertion handler for one removable module: talk first, then initialise.
  Assumes comm_ack and init_done are levels from the module management path.
*/
`timescale 1ns/1ps
`default_nettype none
module cts_insert_fsm import cts_pkg::*; #(
  parameter logic [CNT_W-1:0] TO_CYC = COMM_TO_CYC[CNT_W-1:0]
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       present,
  input  wire logic       go,
  input  wire logic       comm_ack,
  input  wire logic       init_done,
  output var  cts_hs_type hs
);
  cts_ih_type       st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  cts_hs_type       hs_r, hs_nxt;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = '0;
    case (st_r)
      IH_IDLE:  if (present && go) st_nxt = IH_COMM;
      IH_COMM: begin
        cnt_nxt = cnt_r + 1'b1;
        if (!present) st_nxt = IH_IDLE;
        else if (comm_ack) st_nxt = IH_INIT;
        else if (cnt_r == TO_CYC - 1'b1) st_nxt = IH_IDLE;
      end
      IH_INIT: begin
        if (!present) st_nxt = IH_IDLE;
        else if (init_done) st_nxt = IH_READY;
      end
      IH_READY: if (!present) st_nxt = IH_IDLE;
      default:  st_nxt = IH_IDLE;
    endcase
    if (st_nxt != IH_COMM) cnt_nxt = '0;
    hs_nxt.comm_req = (st_nxt == IH_COMM);
    hs_nxt.init_req = (st_nxt == IH_INIT);
    hs_nxt.ready    = (st_nxt == IH_READY);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r  <= IH_IDLE;
      cnt_r <= '0;
      hs_r  <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      hs_r  <= hs_nxt;
    end
  end
  assign hs = hs_r;

  init_after_comm_a: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(hs_r.init_req) |-> $past(hs_r.comm_req) && $past(comm_ack))
    else $error("init started without a completed communication step");
endmodule
`default_nettype wire

// ==== hw/cts_zone_fan.sv ====
/*
  Fan command for one cooling zone, driven by the hottest blade in it.
  Assumes tick is a one-cycle pulse and absent blades report state 0.
*/
`timescale 1ns/1ps
`default_nettype none
module cts_zone_fan import cts_pkg::*; (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             tick,
  input  wire logic             regulate,
  input  wire logic             acoustic,
  input  wire logic [BPZ*3-1:0] states,
  output var  logic [7:0]       fan_cmd
);
  logic [7:0] fan_r, fan_nxt;
  logic [2:0] zmax, tgt;

  function automatic logic [7:0] up(input logic [7:0] c, input logic [7:0] s);
    return (c > FAN_FULL - s) ? FAN_FULL : c + s;
  endfunction

  always_comb begin
    zmax = 3'h0;
    for (int i = 0; i < BPZ; i++) begin
      zmax = cts_max3(zmax, states[i*3 +: 3]);
    end
    tgt     = acoustic ? TS_WARM : TS_COOL;
    fan_nxt = fan_r;
    if (!regulate) begin
      fan_nxt = FAN_FULL;
    end else if (zmax >= TS_WARNING) begin
      fan_nxt = FAN_FULL;
    end else if (tick) begin
      if (zmax == TS_HOTTER) begin
        fan_nxt = up(fan_r, STEP_HOTTER);
      end else if (zmax == TS_HOT) begin
        fan_nxt = up(fan_r, STEP_HOT);
      end else if (zmax > tgt) begin
        fan_nxt = up(fan_r, STEP_HOT);
      end else if (zmax < tgt) begin
        fan_nxt = (fan_r < FAN_MIN + STEP_DOWN) ? FAN_MIN : fan_r - STEP_DOWN;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fan_r <= FAN_FULL;
    end else begin
      fan_r <= fan_nxt;
    end
  end
  assign fan_cmd = fan_r;
endmodule
`default_nettype wire

// ==== sim/cts_far_model.sv ====
/*
  Far-side modules: answer the insertion handshakes and report blade thermal states.
  Assumes the bench sets the wanted states and which slots answer slowly.
*/
`timescale 1ns/1ps
`default_nettype none
module cts_far_model import cts_pkg::*; (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [NUM_MOD-1:0]     present,
  input  wire logic [NUM_MOD-1:0]     slow,
  input  wire logic [NUM_MOD-1:0]     comm_req,
  input  wire logic [NUM_MOD-1:0]     init_req,
  input  wire logic                   blade_pwr_permit,
  input  wire logic [NUM_BLADE-1:0]   blade_shutdown,
  input  wire logic [NUM_BLADE*3-1:0] want,
  output logic      [NUM_MOD-1:0]     comm_ack,
  output logic      [NUM_MOD-1:0]     init_done,
  output logic      [NUM_BLADE*3-1:0] blade_therm
);
  int                   ca [NUM_MOD];
  int                   ci [NUM_MOD];
  logic [NUM_BLADE-1:0] down = '0;
  logic [2:0]           pat  = 3'h0;
  // **********************************
  // Answer delays and blade self-shutdown.
  // **********************************
  always @(posedge clk) begin
    pat <= pat + 3'h1;
    for (int m = 0; m < NUM_MOD; m++) begin
      ca[m] <= (comm_req[m] && !sys_rst) ? ca[m] + 1 : 0;
      ci[m] <= (init_req[m] && !sys_rst) ? ci[m] + 1 : 0;
    end
    for (int b = 0; b < NUM_BLADE; b++) begin
      if (want[3*b+:3] != 3'h7) begin
        down[b] <= 1'b0;
      end else if (blade_shutdown[b]) begin
        down[b] <= 1'b1;
      end
    end
  end
  // Absent blades show a changing pattern, since nobody drives their lines.
  always_comb begin
    for (int m = 0; m < NUM_MOD; m++) begin
      comm_ack[m]  = comm_req[m] && ca[m] >= (slow[m] ? 6 : 1);
      init_done[m] = init_req[m] && ci[m] >= (slow[m] ? 5 : 1);
    end
    for (int b = 0; b < NUM_BLADE; b++) begin
      if (!present[BLADE_BASE+b]) begin
        blade_therm[3*b+:3] = pat;
      end else if (!blade_pwr_permit || down[b]) begin
        blade_therm[3*b+:3] = 3'h0;
      end else begin
        blade_therm[3*b+:3] = want[3*b+:3];
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
  Self-checking bench for the chassis policy block with a cycle model of its outputs.
  Assumes the far-side model answers every handshake well inside the timeout.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top import cts_pkg::*; ;
  localparam int ADJ  = 8;
  localparam int COMM = 16;
  logic                   clk           = 1'b0;
  logic                   sys_rst       = 1'b1;
  logic                   acoustic_mode = 1'b0;
  logic                   thermal_known = 1'b0;
  logic                   psu_mgmt_up   = 1'b0;
  logic [NUM_MOD-1:0]     present       = '0;
  logic [NUM_MOD-1:0]     slow          = '0;
  logic [NUM_BLADE*3-1:0] want          = '0;
  logic [NUM_MOD-1:0]     comm_ack, init_done, comm_req, init_req, mod_ready;
  logic [NUM_BLADE*3-1:0] blade_therm;
  logic [NUM_BLADE-1:0]   blade_shutdown, e_shd;
  logic [NUM_ZONE*8-1:0]  fan_cmd;
  logic                   blade_mgmt_en, blade_pwr_permit, regulating;
  logic [NUM_MOD-1:0]     e_c, e_i, e_r;
  int                     miscompares = 0;
  int                     n_compared  = 0;
  int                     cyc         = 0;
  int                     st [NUM_MOD];
  int                     pf [NUM_ZONE];
  int                     e_fan [NUM_ZONE];
  int                     late [NUM_ZONE];
  int                     seq, e_reg, zmax, b, old, stp, iook, bok, sw, e_tick, tcnt;

  always #2 clk = ~clk;

  cts_policy_top #(.ADJ_CYCLES(CNT_W'(ADJ)), .COMM_CYCLES(CNT_W'(COMM))) dut_u (
    .clk(clk), .sys_rst(sys_rst), .acoustic_mode(acoustic_mode),
    .thermal_known(thermal_known), .psu_mgmt_up(psu_mgmt_up), .present(present),
    .comm_ack(comm_ack), .init_done(init_done), .blade_therm(blade_therm),
    .comm_req(comm_req), .init_req(init_req), .mod_ready(mod_ready),
    .blade_mgmt_en(blade_mgmt_en), .blade_pwr_permit(blade_pwr_permit),
    .regulating(regulating), .blade_shutdown(blade_shutdown), .fan_cmd(fan_cmd));

  cts_far_model far_u (
    .clk(clk), .sys_rst(sys_rst), .present(present), .slow(slow),
    .comm_req(comm_req), .init_req(init_req), .blade_pwr_permit(blade_pwr_permit),
    .blade_shutdown(blade_shutdown), .want(want), .comm_ack(comm_ack),
    .init_done(init_done), .blade_therm(blade_therm));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // **********************************
  // Reference model, advanced on each rising edge from the sampled inputs.
  // **********************************
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 5000) begin
      miscompares++;
      finish_test();
    end else if (sys_rst) begin
      seq = 0;
      e_reg = 0;
      e_tick = 0;
      tcnt = 0;
      e_shd = '0;
      foreach (st[m]) st[m] = 0;
      foreach (pf[z]) begin
        pf[z] = 255;
        e_fan[z] = 255;
        late[z] = 0;
      end
    end else begin
      for (int z = 0; z < NUM_ZONE; z++) begin
        zmax = 0;
        for (int k = 0; k < BPZ; k++) begin
          b = z * BPZ + k;
          if (present[BLADE_BASE+b] && int'(blade_therm[3*b+:3]) > zmax) begin
            zmax = int'(blade_therm[3*b+:3]);
          end
        end
        old = int'(fan_cmd[8*z+:8]);
        // Cycles for which a hot zone below full speed has seen no fan step.
        late[z] = (e_reg != 0 && (zmax == 4 || zmax == 5) && old < 255 && old == pf[z])
                ? late[z] + 1 : 0;
        pf[z] = old;
        stp = (zmax == 5) ? old + 32 : (zmax == 4 || zmax > 2 + acoustic_mode) ? old + 8
            : (zmax < 2 + acoustic_mode) ? old - 4 : old;
        stp = (stp > 255) ? 255 : (stp < 32) ? 32 : stp;
        e_fan[z] = (e_reg == 0 || zmax > 5) ? 255 : (e_tick != 0) ? stp : old;
      end
      e_tick = (tcnt == ADJ - 1) ? 1 : 0;
      tcnt = (tcnt == ADJ - 1) ? 0 : tcnt + 1;
      for (int k = 0; k < NUM_BLADE; k++) begin
        e_shd[k] = present[BLADE_BASE+k] && blade_therm[3*k+:3] == 3'h7;
      end
      sw = (st[PRI_SW] == 3);
      iook = sw;
      bok = 1;
      for (int m = 0; m < NUM_MOD; m++) begin
        if (present[m] && st[m] != 3 && m < PSU_BASE) iook = 0;
        if (present[m] && st[m] != 3 && m >= BLADE_BASE) bok = 0;
        if (!present[m]) st[m] = 0;
        else if (st[m] == 0 && (m < BLADE_BASE || seq >= 2)) st[m] = 1;
        else if ((st[m] == 1 && comm_ack[m]) || (st[m] == 2 && init_done[m])) st[m]++;
      end
      if (seq == 0 && psu_mgmt_up) seq = 1;
      else if (seq == 1 && iook) seq = 2;
      else if (seq >= 2 && !sw) seq = 1;
      else if (seq == 2 && bok) seq = 3;
      e_reg = (seq == 3 && thermal_known) ? 1 : 0;
    end
  end

  // **********************************
  // Every cycle the design's outputs are held against the model.
  // **********************************
  always @(negedge clk) begin
    if (cyc > 0) begin
      for (int m = 0; m < NUM_MOD; m++) begin
        e_c[m] = (st[m] == 1);
        e_i[m] = (st[m] == 2);
        e_r[m] = (st[m] == 3);
      end
      check("comm_req", 16'(comm_req), 16'(e_c));
      check("init_req", 16'(init_req), 16'(e_i));
      check("mod_ready", 16'(mod_ready), 16'(e_r));
      check("blade_mgmt_en", 16'(blade_mgmt_en), 16'(seq >= 2));
      check("blade_pwr_permit", 16'(blade_pwr_permit), 16'(seq == 3));
      check("regulating", 16'(regulating), 16'(e_reg));
      check("blade_shutdown", 16'(blade_shutdown), 16'(e_shd));
      for (int z = 0; z < NUM_ZONE; z++) begin
        check("fan_cmd", 16'(fan_cmd[8*z+:8]), 16'(e_fan[z]));
        check("fan_step_wait", 16'(late[z] > ADJ), 16'h0000);
      end
    end
  end

  // **********************************
  // Scenarios.
  // **********************************
  initial begin
    void'($urandom(32'h77B8C780));
    idle(6);
    sys_rst = 1'b0;
    slow = NUM_MOD'($urandom);
    present = '1;
    idle(20);
    psu_mgmt_up = 1'b1;
    idle(80);
    check("startup_done", 16'(blade_pwr_permit), 16'h0001);
    thermal_known = 1'b1;
    for (int md = 0; md < 2; md++) begin
      for (int s = 0; s < 8; s++) begin
        acoustic_mode = md[0];
        want = 12'(s);
        idle(3 * ADJ);
      end
    end
    want = 12'h249;
    idle(60 * ADJ);
    check("fan_floor", 16'(fan_cmd), 16'h2020);
    want = 12'hB6D;
    idle(10 * ADJ);
    check("fan_ceiling", 16'(fan_cmd), 16'hFFFF);
    repeat (30) begin
      acoustic_mode = 1'($urandom);
      want = 12'($urandom);
      thermal_known = ($urandom % 8) != 0;
      idle(10 + $urandom % 40);
    end
    thermal_known = 1'b1;
    want = 12'h492;
    slow[BLADE_BASE] = 1'b1;
    // Pull one blade in ready, communicate and initialise steps.
    for (int k = 0; k < 4; k++) begin
      present[BLADE_BASE] = 1'b0;
      idle(3);
      present[BLADE_BASE] = 1'b1;
      idle(2 + 4 * k);
    end
    idle(30);
    present[PRI_SW] = 1'b0;
    present[9:6] = 4'h0;
    idle(10);
    present = '1;
    idle(80);
    check("switch_return", 16'(blade_pwr_permit), 16'h0001);
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    idle(80);
    check("after_reset", 16'(regulating), 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
